// ---- core/pif_regs.v ----
// Peripheral interrupt enable and request flag registers behind an APB slave.
//
// Design decisions made here: the address map and the APB slave port.
`timescale 1ns/1ns
//
// Overview of operation
// - No peripheral interrupt reaches the CPU unless the group enable bit is set.
// - Enable register 4 bit 1 enables the serial port 2 collision interrupt.
// - Enable register 4 bit 0 enables the serial port 2 transfer-done interrupt.
// - Unimplemented bits, including enable 4 bits 7-2, ignore writes and read zero.
// - Hardware sets each flag on its event, regardless of any enable bit.
// - Flags 1 holds timer1 gate, adc, uart rx/tx, serial1, capture1, timer2, timer1.
// - Uart receive and transmit flags are read-only; other flags 1 bits read/write.
// - All implemented enable and flag bits clear to zero on every reset.
// - Flags 2 bits 7-3 hold osc fail, comparators, eeprom done, serial1 collision.
// - Flags 2 also holds a capture unit 2 pending flag.

`include "pif_consts.vh"

module pif_regs (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire [7:0] flags1_evt,
  input wire uart_rx_pending,
  input wire uart_tx_pending,
  input wire [7:0] flags2_evt,
  input wire serial2_done_evt,
  input wire serial2_collision_evt,
  output reg periph_irq
);

  // ==========================================================================
  // Address decode
  // ==========================================================================

  // Maps a byte address onto a register select code; unmapped gives none.
  function [2:0] reg_sel;
    input [7:0] addr;
    begin
      case (addr)
        `PIF_OFS_ENABLE_4: reg_sel = `PIF_SEL_ENABLE_4;
        `PIF_OFS_FLAGS_1: reg_sel = `PIF_SEL_FLAGS_1;
        `PIF_OFS_FLAGS_2: reg_sel = `PIF_SEL_FLAGS_2;
        `PIF_OFS_GLOBAL_CTRL: reg_sel = `PIF_SEL_GLOBAL_CTRL;
        `PIF_OFS_ENABLE_1: reg_sel = `PIF_SEL_ENABLE_1;
        `PIF_OFS_ENABLE_2: reg_sel = `PIF_SEL_ENABLE_2;
        `PIF_OFS_SERIAL2_STAT: reg_sel = `PIF_SEL_SERIAL2_STAT;
        default: reg_sel = `PIF_SEL_NONE;
      endcase
    end
  endfunction

  reg [7:0] enable4_r;
  reg [7:0] flags1_r;
  reg [7:0] flags2_r;
  reg [7:0] global_ctrl_r;
  reg [7:0] enable1_r;
  reg [7:0] enable2_r;
  reg [7:0] serial2_stat_r;
  reg [7:0] enable4_nxt;
  reg [7:0] flags1_nxt;
  reg [7:0] flags2_nxt;
  reg [7:0] global_ctrl_nxt;
  reg [7:0] enable1_nxt;
  reg [7:0] enable2_nxt;
  reg [7:0] serial2_stat_nxt;
  reg [7:0] rd_byte;
  reg irq_nxt;

  wire [2:0] sel;
  wire access;
  wire wr_now;
  wire [7:0] wbyte;
  wire [7:0] serial2_evt;

  // The slave inserts one wait state, so every transfer completes on its second access cycle.
  assign sel = reg_sel(paddr);
  assign access = psel & penable;
  assign wr_now = access & pready & pwrite & (sel != `PIF_SEL_NONE);
  assign wbyte = pwdata[7:0];
  assign serial2_evt = {6'h00, serial2_collision_evt, serial2_done_evt};

  // ==========================================================================
  // Register next-state logic
  // ==========================================================================

  // Software writes land first, then hardware events are ORed in so a set wins over a clear.
  always @* begin
    enable4_nxt = enable4_r;
    flags1_nxt = flags1_r;
    flags2_nxt = flags2_r;
    global_ctrl_nxt = global_ctrl_r;
    enable1_nxt = enable1_r;
    enable2_nxt = enable2_r;
    serial2_stat_nxt = serial2_stat_r;
    if (wr_now) begin
      case (sel)
        `PIF_SEL_ENABLE_4: enable4_nxt = wbyte & `PIF_EN4_MASK;
        `PIF_SEL_FLAGS_1: flags1_nxt = wbyte & `PIF_F1_SW_MASK;
        `PIF_SEL_FLAGS_2: flags2_nxt = wbyte & `PIF_F2_MASK;
        `PIF_SEL_GLOBAL_CTRL: global_ctrl_nxt = wbyte & `PIF_GC_MASK;
        `PIF_SEL_ENABLE_1: enable1_nxt = wbyte;
        `PIF_SEL_ENABLE_2: enable2_nxt = wbyte & `PIF_F2_MASK;
        `PIF_SEL_SERIAL2_STAT: serial2_stat_nxt = serial2_stat_r & ~(wbyte & `PIF_S2_MASK);
        default: enable4_nxt = enable4_r;
      endcase
    end
    // Events set flags whatever the enables hold; uart bits follow the uart's own state.
    flags1_nxt = (flags1_nxt | (flags1_evt & `PIF_F1_SW_MASK)) & `PIF_F1_SW_MASK;
    flags1_nxt[`PIF_F1_UART_RX_BIT] = uart_rx_pending;
    flags1_nxt[`PIF_F1_UART_TX_BIT] = uart_tx_pending;
    flags2_nxt = flags2_nxt | (flags2_evt & `PIF_F2_MASK);
    serial2_stat_nxt = serial2_stat_nxt | serial2_evt;
  end

  // Interrupt request: any flag with its enable, gated by the group and global enables.
  always @* begin
    irq_nxt = global_ctrl_r[`PIF_GC_GLOBAL_BIT] & global_ctrl_r[`PIF_GC_GROUP_BIT] &
              (|(flags1_r & enable1_r) | |(flags2_r & enable2_r) |
               |(serial2_stat_r & enable4_r));
  end

  // Read multiplexer; unmapped and unimplemented bits read as zero.
  always @* begin
    case (sel)
      `PIF_SEL_ENABLE_4: rd_byte = enable4_r;
      `PIF_SEL_FLAGS_1: rd_byte = flags1_r;
      `PIF_SEL_FLAGS_2: rd_byte = flags2_r;
      `PIF_SEL_GLOBAL_CTRL: rd_byte = global_ctrl_r;
      `PIF_SEL_ENABLE_1: rd_byte = enable1_r;
      `PIF_SEL_ENABLE_2: rd_byte = enable2_r;
      `PIF_SEL_SERIAL2_STAT: rd_byte = serial2_stat_r;
      default: rd_byte = `PIF_RST_BYTE;
    endcase
  end

  // ==========================================================================
  // Registers
  // ==========================================================================

  // State and bus answer flip-flops; every bit clears on reset.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable4_r <= `PIF_RST_BYTE;
      flags1_r <= `PIF_RST_BYTE;
      flags2_r <= `PIF_RST_BYTE;
      global_ctrl_r <= `PIF_RST_BYTE;
      enable1_r <= `PIF_RST_BYTE;
      enable2_r <= `PIF_RST_BYTE;
      serial2_stat_r <= `PIF_RST_BYTE;
      periph_irq <= 1'b0;
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= `PIF_RST_WORD;
    end else begin
      enable4_r <= enable4_nxt;
      flags1_r <= flags1_nxt;
      flags2_r <= flags2_nxt;
      global_ctrl_r <= global_ctrl_nxt;
      enable1_r <= enable1_nxt;
      enable2_r <= enable2_nxt;
      serial2_stat_r <= serial2_stat_nxt;
      periph_irq <= irq_nxt;
      // Answer on the second access cycle, then drop ready so the next transfer waits again.
      pready <= access & ~pready;
      pslverr <= access & ~pready & (sel == `PIF_SEL_NONE);
      if (access & ~pready & ~pwrite) begin
        prdata <= {24'h000000, rd_byte};
      end
    end
  end

endmodule

// ---- core/pif_consts.vh ----
// Register offsets, field positions and reset values of the peripheral interrupt flag block.
`ifndef PIF_CONSTS_VH
`define PIF_CONSTS_VH

// ==========================================================================
// Register byte offsets
// ==========================================================================
`define PIF_OFS_ENABLE_4 8'h00
`define PIF_OFS_FLAGS_1 8'h04
`define PIF_OFS_FLAGS_2 8'h08
`define PIF_OFS_GLOBAL_CTRL 8'h0C
`define PIF_OFS_ENABLE_1 8'h10
`define PIF_OFS_ENABLE_2 8'h14
`define PIF_OFS_SERIAL2_STAT 8'h18

// ==========================================================================
// Register select codes returned by the address decoder
// ==========================================================================
`define PIF_SEL_NONE 3'h0
`define PIF_SEL_ENABLE_4 3'h1
`define PIF_SEL_FLAGS_1 3'h2
`define PIF_SEL_FLAGS_2 3'h3
`define PIF_SEL_GLOBAL_CTRL 3'h4
`define PIF_SEL_ENABLE_1 3'h5
`define PIF_SEL_ENABLE_2 3'h6
`define PIF_SEL_SERIAL2_STAT 3'h7

// ==========================================================================
// Field positions and implemented-bit masks
// ==========================================================================
`define PIF_EN4_COLLISION_BIT 1
`define PIF_EN4_DONE_BIT 0
`define PIF_EN4_MASK 8'h03
`define PIF_F1_UART_RX_BIT 5
`define PIF_F1_UART_TX_BIT 4
`define PIF_F1_SW_MASK 8'hCF
`define PIF_F2_MASK 8'hF9
`define PIF_F2_CAPTURE2_BIT 0
`define PIF_GC_GLOBAL_BIT 1
`define PIF_GC_GROUP_BIT 0
`define PIF_GC_MASK 8'h03
`define PIF_S2_MASK 8'h03

// ==========================================================================
// Reset values
// ==========================================================================
`define PIF_RST_BYTE 8'h00
`define PIF_RST_WORD 32'h0000_0000

`endif

// ---- bench/pif_regs_assertions.sv ----
// Concurrent checks on the ports of the peripheral interrupt flag block.
`timescale 1ns/1ns
// ==========================================================
// Checker module
module pif_regs_chk (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire periph_irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  rdy_one_wait_a: assert property (psel && penable && !pready |=> pready) else $error("no ready");
  rdy_pulse_a: assert property (pready |=> !pready) else $error("ready too long");
  err_decode_a: assert property (pready |-> pslverr == (paddr > 8'h18 || paddr[1:0] != 2'h0))
    else $error("bad error flag");
  err_read_a: assert property (pslverr && !pwrite |-> prdata == 32'h0) else $error("error data");
  upper_zero_a: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("upper bits set");
  en4_unused_a: assert property (pready && !pwrite && paddr == 8'h00 |-> prdata[7:2] == 6'h00)
    else $error("enable bits 7-2 set");
  f2_unused_a: assert property (pready && !pwrite && paddr == 8'h08 |-> prdata[2:1] == 2'h0)
    else $error("flag bits 2-1 set");
  reset_quiet_a: assert property ($rose(presetn) |-> !periph_irq && !pready)
    else $error("outputs after reset");
  cover property ($rose(periph_irq));
  cover property (pslverr);
  cover property (pready && pwrite && paddr == 8'h00);
endmodule

bind pif_regs pif_regs_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .periph_irq(periph_irq));

// ---- bench/peripheral_irq_flag_enable_regs_test.sv ----
// Self-checking testbench for the peripheral interrupt flag block.
`timescale 1ns/1ns
`include "pif_consts.vh"
// ==========================================================
// Testbench top
module peripheral_irq_flag_enable_regs_test;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, urx = 0, col = 0;
  logic [7:0] paddr = 0, f1e = 0, f2e = 0;
  logic [31:0] pwdata = 0, prdata, rdat, v, a, b, seed = 32'h00014E06;
  logic pready, pslverr, periph_irq, rerr;
  int errors = 0, total_checks = 0, i, f1, f2;
  pif_regs i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .flags1_evt(f1e), .uart_rx_pending(urx), .uart_tx_pending(urx), .flags2_evt(f2e),
    .serial2_done_evt(col), .serial2_collision_evt(col), .periph_irq(periph_irq));
  // Clock of 10 ns and the watchdog that cuts a hang short.
  initial forever #5 pclk = ~pclk;
  initial begin
    repeat (5000) @(posedge pclk);
    errors++;
    close_out;
  end
  // Linear feedback shift register for random values.
  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction
  task chk(string n, logic [31:0] seen, logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
    end
  endtask
  // One APB transfer; ready is looked at mid-cycle, the request drops after the completion edge.
  task apb(logic w, logic [7:0] ad, logic [31:0] d);
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= ad; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do begin @(negedge pclk); end while (pready !== 1'b1);
    rdat = prdata; rerr = pslverr;
    @(posedge pclk);
    psel <= 0; penable <= 0;
  endtask
  // One-cycle event pulse; settling and comparing the interrupt line is left to the irq task.
  task ev(logic [7:0] x, logic [7:0] y, logic c);
    @(posedge pclk);
    f1e <= x; f2e <= y; col <= c;
    @(posedge pclk);
    f1e <= 0; f2e <= 0; col <= 0;
  endtask
  task irq(logic e);
    repeat (3) @(posedge pclk);
    chk("irq", {31'h0, periph_irq}, {31'h0, e});
  endtask
  task close_out;
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1;
    for (i = 0; i < 8; i++) begin
      apb(0, i * 4, 0);
      chk("reset", rdat, 0);
      chk("err", {31'h0, rerr}, i == 7);
    end
    $display("reset test done");
    v = rnd(); apb(1, `PIF_OFS_ENABLE_4, v); apb(0, `PIF_OFS_ENABLE_4, 0);
    chk("en4", rdat, v & 32'h3);
    @(posedge pclk) urx <= 1;
    v = rnd(); apb(1, `PIF_OFS_FLAGS_1, v); apb(0, `PIF_OFS_FLAGS_1, 0);
    f1 = v & 32'hCF;
    chk("f1", rdat, f1 | 32'h30);
    a = rnd(); b = rnd(); ev(a[7:0], b[7:0], 0);
    f1 = f1 | (a & 32'hCF); f2 = b & 32'hF9;
    apb(0, `PIF_OFS_FLAGS_1, 0); chk("f1 evt", rdat, f1 | 32'h30);
    apb(0, `PIF_OFS_FLAGS_2, 0); chk("f2 evt", rdat, f2);
    $display("flag test done");
    apb(1, `PIF_OFS_FLAGS_1, 0); apb(1, `PIF_OFS_FLAGS_2, 0); apb(1, `PIF_OFS_ENABLE_4, 0);
    apb(1, `PIF_OFS_ENABLE_1, 1); apb(1, `PIF_OFS_GLOBAL_CTRL, 1);
    ev(1, 0, 0); irq(0);
    apb(1, `PIF_OFS_GLOBAL_CTRL, 2); irq(0);
    apb(1, `PIF_OFS_GLOBAL_CTRL, 3); irq(1);
    apb(1, `PIF_OFS_ENABLE_1, 0); irq(0);
    apb(1, `PIF_OFS_ENABLE_4, 2); ev(0, 0, 1); irq(1);
    apb(1, `PIF_OFS_SERIAL2_STAT, 2); irq(0);
    apb(1, `PIF_OFS_ENABLE_4, 1); irq(1);
    apb(1, `PIF_OFS_SERIAL2_STAT, 1); irq(0);
    $display("irq test done");
    close_out;
  end
endmodule
